// [design/slcd_cfg.svh]
// constants of the segment lcd configuration and clocking block
`ifndef SLCD_CFG_SVH
`define SLCD_CFG_SVH
// register indices; byte address is four times the index
`define SLCD_IDX_CTRL_A 8'hE4
`define SLCD_IDX_CTRL_B 8'hE5
`define SLCD_IDX_FRR 8'hE6
`define SLCD_IDX_STATUS 8'hE7
`define SLCD_ADDR_LSB 2
// reset values
`define SLCD_RST_CTRL_A 8'h00
`define SLCD_RST_CTRL_B 8'h00
`define SLCD_RST_FRR 8'h00
// control a fields
`define SLCD_A_ENABLE 7
`define SLCD_A_CCD 1
`define SLCD_A_BLANK 0
`define SLCD_A_WMASK 8'h83
// control b fields
`define SLCD_B_CS 7
`define SLCD_B_HALF 6
`define SLCD_B_DUTY_HI 5
`define SLCD_B_DUTY_LO 4
`define SLCD_B_PM_TOP 3
// frame rate fields; bits 7 and 3 reserved
`define SLCD_F_PS_HI 6
`define SLCD_F_PS_LO 4
`define SLCD_F_CD_HI 2
`define SLCD_F_CD_LO 0
`define SLCD_F_WMASK 8'h77
// last frame count in prescaled periods, one less than the frame length
`define SLCD_K_THIRD 3'h5
`define SLCD_K_OTHER 3'h7
// status fields
`define SLCD_S_RUN 0
`define SLCD_S_BLANK 1
`define SLCD_S_PH_LO 2
`define SLCD_S_PH_HI 4
`endif

// [design/slcd_pkg.sv]
// types of the segment lcd configuration and clocking block
package slcd_pkg;
	// driver states, gray along off -> run -> blank
	typedef enum logic [1:0] {
		SLCD_OFF = 2'b00,
		SLCD_RUN = 2'b01,
		SLCD_BLANK = 2'b11
	} slcd_state_t;

	// pin drive view towards the glass
	typedef struct packed {
		logic [3:0] commonPinEn;
		logic [39:0] segmentPinEn;
		logic grounded;
		logic supplyOn;
		logic halfBias;
		logic staticBias;
	} slcd_pins_t;

	// whole block state
	typedef struct packed {
		logic [7:0] ctrlA;
		logic [7:0] ctrlB;
		logic [7:0] frr;
		slcd_state_t st;
		logic [1:0] syncOsc;
		logic [1:0] syncExt;
		logic lastSrc;
		logic [11:0] preCnt;
		logic [2:0] divCnt;
		logic [2:0] frmCnt;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		slcd_pins_t pins;
		logic panelTick;
		logic frameStart;
	} slcd_regs_t;
endpackage : slcd_pkg

// [design/slcd_top.sv]
// segment lcd configuration, clock prescaler and frame timing with apb registers
//Contract
//- contrast supply disable set switches the internal driver supply off.
//- blanking takes effect at frame end; then all pins drive ground.
//- clock source select: zero system clock, one asynchronous clock.
//- asynchronous clock is oscillator or external pin, per external select.
//- duty select codes give static, 1/2, 1/3 and 1/4 duty.
//- duty decides how many common pins drive; rest stay port pins.
//- port mask picks segment pins driven, 13 up to 40.
//- mask codes map to 13,15,17,19,21,23,24,25,27..39,40 segments.
//- on small variants the top mask bit is reserved, reads zero.
//- frame rate bits 7 and 3 ignore writes and read zero.
//- prescaler tap select divides by 16,64,128..4096.
//- tap output is divided again to form the prescaled panel clock.
//- clock divide field divides by its code plus one.
//- a frame lasts 6 prescaled periods at 1/3 duty, otherwise 8.
//- enable starts the driver, clearing it stops it at once.
//
// Added by the designer: register access over APB.
`include "slcd_cfg.svh"

module slcd_top #(
	parameter bit WIDE_PINS = 1'b1,
	parameter int SEG_PINS = 40
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic oscClkPin,
	input wire logic extClkPin,
	input wire logic externalClockInputSelect,
	output logic [3:0] commonPinEn,
	output logic [SEG_PINS-1:0] segmentPinEn,
	output logic pinsGrounded,
	output logic internalSupplyOn,
	output logic halfBias,
	output logic staticBias,
	output logic prescaledPanelClock,
	output logic frameStart
);
	//****************************************************************
	// decoding functions
	//****************************************************************

	// prescaler tap mask, counter low bits all ones marks a tap
	function automatic logic [11:0] tapMask(input logic [2:0] sel);
		case (sel)
			3'h0: tapMask = 12'h00F;
			3'h1: tapMask = 12'h03F;
			3'h2: tapMask = 12'h07F;
			3'h3: tapMask = 12'h0FF;
			3'h4: tapMask = 12'h1FF;
			3'h5: tapMask = 12'h3FF;
			3'h6: tapMask = 12'h7FF;
			default: tapMask = 12'hFFF;
		endcase
	endfunction : tapMask

	// number of segment pins for a mask code
	function automatic logic [5:0] segCount(input logic [3:0] pm);
		case (pm)
			4'h0: segCount = 6'h0D;
			4'h1: segCount = 6'h0F;
			4'h2: segCount = 6'h11;
			4'h3: segCount = 6'h13;
			4'h4: segCount = 6'h15;
			4'h5: segCount = 6'h17;
			4'h6: segCount = 6'h18;
			4'h7: segCount = 6'h19;
			4'h8: segCount = 6'h1B;
			4'h9: segCount = 6'h1D;
			4'hA: segCount = 6'h1F;
			4'hB: segCount = 6'h21;
			4'hC: segCount = 6'h23;
			4'hD: segCount = 6'h25;
			4'hE: segCount = 6'h27;
			default: segCount = 6'h28;
		endcase
	endfunction : segCount

	// common pins in use per duty code
	function automatic logic [3:0] comMask(input logic [1:0] duty);
		case (duty)
			2'h0: comMask = 4'h1;
			2'h1: comMask = 4'h3;
			2'h2: comMask = 4'h7;
			default: comMask = 4'hF;
		endcase
	endfunction : comMask

	//****************************************************************
	// state and decode
	//****************************************************************

	slcd_pkg::slcd_regs_t q;
	slcd_pkg::slcd_regs_t d;
	logic [5:0] segNum;
	logic [SEG_PINS-1:0] segMask;
	logic [1:0] dutyCode;

	// top mask bit kept only on the wide variant
	assign segNum = segCount({q.ctrlB[`SLCD_B_PM_TOP] & WIDE_PINS, q.ctrlB[2:0]});
	assign dutyCode = q.ctrlB[`SLCD_B_DUTY_HI:`SLCD_B_DUTY_LO];

	// segment enable mask, one bit per pin
	genvar gi;
	generate
		for (gi = 0; gi < SEG_PINS; gi++) begin : gSeg
			assign segMask[gi] = (6'(gi) < segNum);
		end
	endgenerate

	//****************************************************************
	// next state
	//****************************************************************

	logic srcLevel;
	logic clkTick;
	logic tapTick;
	logic frameEnd;
	logic [2:0] frameLast;
	logic enabled;
	logic access;
	logic mapped;
	logic [7:0] regIdx;
	logic [7:0] rdByte;
	logic [7:0] wrByte;
	logic [7:0] statusByte;

	// sequential intent of every field
	always_comb begin
		d = q;
		d.pready = 1'b0;
		d.pslverr = 1'b0;
		d.panelTick = 1'b0;
		d.frameStart = 1'b0;
		tapTick = 1'b0;
		frameEnd = 1'b0;
		enabled = q.ctrlA[`SLCD_A_ENABLE];

		// asynchronous clock pins: two flops before use
		d.syncOsc = {q.syncOsc[0], oscClkPin};
		d.syncExt = {q.syncExt[0], extClkPin};
		srcLevel = externalClockInputSelect ? q.syncExt[1] : q.syncOsc[1];
		d.lastSrc = srcLevel;
		clkTick = q.ctrlB[`SLCD_B_CS] ? (srcLevel & ~q.lastSrc) : 1'b1;

		// apb slave, answer one cycle into the access phase
		access = psel & penable;
		regIdx = paddr[`SLCD_ADDR_LSB+7:`SLCD_ADDR_LSB];
		mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
			((regIdx == `SLCD_IDX_CTRL_A) || (regIdx == `SLCD_IDX_CTRL_B) ||
			(regIdx == `SLCD_IDX_FRR) || (regIdx == `SLCD_IDX_STATUS));
		statusByte = 8'h00;
		statusByte[`SLCD_S_RUN] = (q.st != slcd_pkg::SLCD_OFF);
		statusByte[`SLCD_S_BLANK] = (q.st == slcd_pkg::SLCD_BLANK);
		statusByte[`SLCD_S_PH_HI:`SLCD_S_PH_LO] = q.frmCnt;
		case (regIdx)
			`SLCD_IDX_CTRL_A: rdByte = q.ctrlA;
			`SLCD_IDX_CTRL_B: rdByte = q.ctrlB;
			`SLCD_IDX_FRR: rdByte = q.frr;
			`SLCD_IDX_STATUS: rdByte = statusByte;
			default: rdByte = 8'h00;
		endcase
		wrByte = pwdata[7:0];
		if (access && !q.pready) begin
			d.pready = 1'b1;
			d.pslverr = ~mapped;
			d.prdata = (mapped && !pwrite) ? {24'h00_0000, rdByte} : 32'h0000_0000;
		end
		if (access && q.pready && pwrite && mapped) begin
			case (regIdx)
				`SLCD_IDX_CTRL_A: d.ctrlA = wrByte & `SLCD_A_WMASK;
				`SLCD_IDX_CTRL_B: begin
					d.ctrlB = wrByte;
					d.ctrlB[`SLCD_B_PM_TOP] = wrByte[`SLCD_B_PM_TOP] & WIDE_PINS;
				end
				`SLCD_IDX_FRR: d.frr = wrByte & `SLCD_F_WMASK;
				default: d.ctrlA = q.ctrlA;
			endcase
		end

		// prescaler tap and clock divider
		if (!enabled) begin
			d.preCnt = 12'h000;
			d.divCnt = 3'h0;
			d.frmCnt = 3'h0;
		end else if (clkTick) begin
			d.preCnt = q.preCnt + 12'h001;
			tapTick = ((q.preCnt & tapMask(q.frr[`SLCD_F_PS_HI:`SLCD_F_PS_LO])) ==
				tapMask(q.frr[`SLCD_F_PS_HI:`SLCD_F_PS_LO]));
		end
		if (enabled && tapTick) begin
			if (q.divCnt >= q.frr[`SLCD_F_CD_HI:`SLCD_F_CD_LO]) begin
				d.divCnt = 3'h0;
				d.panelTick = 1'b1;
			end else begin
				d.divCnt = q.divCnt + 3'h1;
			end
		end

		// frame length in prescaled periods
		frameLast = (dutyCode == 2'h2) ? `SLCD_K_THIRD : `SLCD_K_OTHER;
		if (enabled && q.panelTick) begin
			if (q.frmCnt >= frameLast) begin
				d.frmCnt = 3'h0;
				frameEnd = 1'b1;
			end else begin
				d.frmCnt = q.frmCnt + 3'h1;
			end
		end

		// driver state: start, blank at frame end, stop at once
		case (q.st)
			slcd_pkg::SLCD_OFF: begin
				if (enabled) begin
					d.st = slcd_pkg::SLCD_RUN;
					d.frameStart = 1'b1;
				end
			end
			slcd_pkg::SLCD_RUN: begin
				if (!enabled) begin
					d.st = slcd_pkg::SLCD_OFF;
				end else if (frameEnd) begin
					d.frameStart = 1'b1;
					if (q.ctrlA[`SLCD_A_BLANK]) begin
						d.st = slcd_pkg::SLCD_BLANK;
					end
				end
			end
			slcd_pkg::SLCD_BLANK: begin
				if (!enabled) begin
					d.st = slcd_pkg::SLCD_OFF;
				end else if (frameEnd) begin
					d.frameStart = 1'b1;
					if (!q.ctrlA[`SLCD_A_BLANK]) begin
						d.st = slcd_pkg::SLCD_RUN;
					end
				end
			end
			default: d.st = slcd_pkg::SLCD_OFF;
		endcase

		// pin view from the next state
		if (d.st == slcd_pkg::SLCD_OFF) begin
			d.pins.commonPinEn = 4'h0;
			d.pins.segmentPinEn = 40'h00_0000_0000;
		end else begin
			d.pins.commonPinEn = comMask(dutyCode);
			d.pins.segmentPinEn = 40'(segMask);
		end
		d.pins.grounded = (d.st == slcd_pkg::SLCD_BLANK);
		d.pins.supplyOn = (d.st != slcd_pkg::SLCD_OFF) && !q.ctrlA[`SLCD_A_CCD];
		d.pins.staticBias = (dutyCode == 2'h0);
		d.pins.halfBias = !d.pins.staticBias && q.ctrlB[`SLCD_B_HALF];
	end

	//****************************************************************
	// state register
	//****************************************************************

	// all state in one register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.ctrlA <= `SLCD_RST_CTRL_A;
			q.ctrlB <= `SLCD_RST_CTRL_B;
			q.frr <= `SLCD_RST_FRR;
			q.st <= slcd_pkg::SLCD_OFF;
		end else begin
			q <= d;
		end
	end

	//****************************************************************
	// outputs, all from flops
	//****************************************************************

	// drive the ports from the registered state
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign commonPinEn = q.pins.commonPinEn;
	assign segmentPinEn = q.pins.segmentPinEn[SEG_PINS-1:0];
	assign pinsGrounded = q.pins.grounded;
	assign internalSupplyOn = q.pins.supplyOn;
	assign halfBias = q.pins.halfBias;
	assign staticBias = q.pins.staticBias;
	assign prescaledPanelClock = q.panelTick;
	assign frameStart = q.frameStart;
endmodule : slcd_top

// [test/slcd_glass_model.sv]
// passive segment glass seen from the lcd pins
module slcd_glass_model (
	input wire logic ref_clk,
	input wire logic [3:0] commonPinEn,
	input wire logic pinsGrounded,
	input wire logic frameStart,
	output int frames
);
	timeunit 1ns;
	timeprecision 1ps;
	initial frames = 0;
	// count frames that reach the glass with commons driven and not blanked
	always @(posedge ref_clk) begin
		if (frameStart && commonPinEn[0] && !pinsGrounded) frames <= frames + 1;
	end
endmodule : slcd_glass_model

// [test/slcd_top_assertions.sv]
// port assertions of the lcd configuration block
module slcd_top_assertions #(
	parameter int SEG_PINS = 40
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] commonPinEn,
	input wire logic [SEG_PINS-1:0] segmentPinEn,
	input wire logic pinsGrounded,
	input wire logic internalSupplyOn,
	input wire logic halfBias,
	input wire logic staticBias,
	input wire logic prescaledPanelClock,
	input wire logic frameStart
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	ready_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("no answer after one wait state");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
	err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
	com_shape_a: assert property (commonPinEn inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
		else $error("bad common pin set");
	seg_floor_a: assert property (|segmentPinEn |-> &segmentPinEn[12:0] && commonPinEn[0])
		else $error("segment set below floor");
	supply_run_a: assert property (internalSupplyOn |-> commonPinEn[0])
		else $error("supply on while stopped");
	bias_static_a: assert property (staticBias |-> !halfBias)
		else $error("half bias in static");
	ground_run_a: assert property (pinsGrounded |-> commonPinEn[0])
		else $error("grounded while stopped");
	tick_gap_a: assert property (prescaledPanelClock |=> !prescaledPanelClock [*8])
		else $error("panel ticks too close");
	frame_gap_a: assert property (frameStart |=> !frameStart [*8])
		else $error("frames too close");
endmodule : slcd_top_assertions
bind slcd_top slcd_top_assertions #(.SEG_PINS(SEG_PINS)) slcd_top_assertions_inst (
	.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .commonPinEn(commonPinEn), .segmentPinEn(segmentPinEn),
	.pinsGrounded(pinsGrounded), .internalSupplyOn(internalSupplyOn), .halfBias(halfBias),
	.staticBias(staticBias), .prescaledPanelClock(prescaledPanelClock), .frameStart(frameStart));

// [test/slcd_top_tb.sv]
// self-checking bench of the lcd configuration and clocking block
module slcd_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, rst, psel, penable, pwrite, oscPin, extPin, extSel, err;
	logic pready, pslverr, gnd, supOn, halfB, statB, panelClk, fs;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] common_pin;
	logic [39:0] segment_pin;
	logic [2:0] ckDiv = 3'h0;
	logic [7:0] v;
	int n_mismatch = 0, checks = 0, frames, p;
	int segs[16] = '{13, 15, 17, 19, 21, 23, 24, 25, 27, 29, 31, 33, 35, 37, 39, 40};
	slcd_top slcd_top_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .oscClkPin(oscPin), .extClkPin(extPin),
		.externalClockInputSelect(extSel), .commonPinEn(common_pin), .segmentPinEn(segment_pin),
		.pinsGrounded(gnd), .internalSupplyOn(supOn), .halfBias(halfB), .staticBias(statB),
		.prescaledPanelClock(panelClk), .frameStart(fs));
	slcd_glass_model slcd_glass_model_inst (.ref_clk(ref_clk), .commonPinEn(common_pin),
		.pinsGrounded(gnd), .frameStart(fs), .frames(frames));
	initial begin
		ref_clk = 1'h0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// async pins: external period 8 clocks, oscillator 4 clocks
	always @(posedge ref_clk) begin
		ckDiv <= ckDiv + 3'h1;
		extPin <= ckDiv[2];
		oscPin <= ckDiv[1];
	end
	task automatic complete_run();
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= 32'(d);
		@(posedge ref_clk);
		penable <= 1'h1;
		do @(posedge ref_clk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	// cycles until the next panel tick or frame start
	task automatic waitOn(input bit tick);
		p = 0;
		do begin
			@(posedge ref_clk);
			p++;
		end while ((tick ? panelClk : fs) !== 1'h1 && p < 40000);
	endtask : waitOn
	// configure, enable, check pins and the frame length k*n*d*per
	task automatic frame(input logic [7:0] b, input logic [7:0] f, input logic ccd, input int per);
		apb(1'h1, 12'h390, 8'h00);
		apb(1'h1, 12'h394, b);
		apb(1'h1, 12'h398, f);
		apb(1'h1, 12'h390, {1'h1, 5'h00, ccd, 1'h0});
		waitOn(0);
		chk(common_pin, (4'h2 << b[5:4]) - 4'h1);
		chk(segment_pin, (41'h1 << segs[b[3:0]]) - 41'h1);
		chk({statB, halfB, supOn}, {b[5:4] == 2'h0, b[6] && b[5:4] != 2'h0, !ccd});
		waitOn(0);
		waitOn(0);
		chk(p, (b[5:4] == 2'h2 ? 6 : 8) * 16 * (f[2:0] + 1) * per);
	endtask : frame
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		void'($urandom(32'h0000_430c));
		{rst, psel, penable, pwrite, extSel, paddr, pwdata} = {1'h1, 48'h0};
		repeat (4) @(posedge ref_clk);
		rst <= 1'h0;
		apb(1'h0, 12'h394, 8'h00);
		chk(rd, 40'h0);
		apb(1'h0, 12'h398, 8'h00);
		chk(rd, 40'h0);
		repeat (4) begin
			v = $urandom;
			apb(1'h1, 12'h398, v);
			apb(1'h0, 12'h398, 8'h00);
			chk(rd, v & 8'h77);
			v = $urandom;
			apb(1'h1, 12'h394, v);
			apb(1'h0, 12'h394, 8'h00);
			chk(rd, v);
		end
		apb(1'h0, 12'h3a0, 8'h00);
		chk({err, rd}, 40'h01_0000_0000);
		for (int i = 0; i < 16; i++) begin
			frame({1'h0, 1'($urandom), i[1:0], i[3:0]}, 8'($urandom % 2), 1'($urandom), 1);
		end
		// every tap with a shrinking divider, read off the panel tick period
		for (int t = 0; t < 8; t++) begin
			apb(1'h1, 12'h398, {1'h0, 3'(t), 1'h0, 3'(7 - t)});
			waitOn(1);
			waitOn(1);
			chk(p, (t == 0 ? 16 : 32 << t) * (8 - t));
		end
		for (int s = 0; s < 2; s++) begin
			extSel <= 1'(s);
			frame(8'h83, 8'h00, 1'h0, s ? 8 : 4);
		end
		apb(1'h1, 12'h390, 8'h81);
		waitOn(0);
		repeat (3) @(posedge ref_clk);
		chk({gnd, common_pin}, 5'h11);
		apb(1'h1, 12'h390, 8'h00);
		repeat (3) @(posedge ref_clk);
		chk({gnd, common_pin, segment_pin, supOn}, 46'h0);
		chk(frames > 0, 1);
		complete_run();
	end
	initial begin
		repeat (100000) @(posedge ref_clk);
		n_mismatch++;
		complete_run();
	end
endmodule : slcd_top_tb
